// ---- vidsmp_pkg.sv ----
`default_nettype none

package vidsmp_pkg;

	// ========================================================
	// Operating modes
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_MOTION_COMP,
		MODE_MOTION_DECOMP,
		MODE_MPEG,
		MODE_STILL_COMP,
		MODE_STILL_DECOMP
	} vidsmp_mode_e;

	// ========================================================
	// Pixel word of the extended bus
	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] chroma;
		logic [7:0] luma;
	} vidsmp_pix_s;

	// ========================================================
	// Pin levels as they pass the input synchroniser
	typedef struct packed {
		logic        pclk;
		logic        qual;
		logic        hsync;
		logic        vsync;
		logic        field_in;
		vidsmp_pix_s pix;
	} vidsmp_pins_s;

	// ========================================================
	// Host configuration
	typedef struct packed {
		logic         qual_sel;
		logic         field_src;
		logic         top_sel;
		logic         vedge;
		logic         hedge;
		logic         sync_int;
		vidsmp_mode_e mode;
		logic [9:0]   first_line;
		logic [9:0]   last_line;
		logic [9:0]   first_pix;
		logic [9:0]   last_pix;
		logic [9:0]   line_tot;
		logic [9:0]   frame_tot;
		logic [9:0]   hs_start;
		logic [9:0]   vs_size;
	} vidsmp_cfg_s;

	// ========================================================
	// Whole state of the sampler
	typedef struct packed {
		vidsmp_pins_s p1;
		vidsmp_pins_s p2;
		vidsmp_pins_s p3;
		logic         pclk_lvl;
		vidsmp_cfg_s  cfg;
		logic         hs_prev;
		logic         vs_prev;
		logic [9:0]   pix_cnt;
		logic [9:0]   line_cnt;
		logic         field_top;
		logic         in_win;
		vidsmp_pix_s  out_pix;
		logic         out_valid;
		vidsmp_pix_s  still_out;
		logic         still_pend;
		vidsmp_pix_s  still_in;
		logic         still_avail;
		vidsmp_pix_s  bus_out;
		logic         bus_oe;
		logic [9:0]   gen_h;
		logic [9:0]   gen_v;
		logic         gen_hs;
		logic         gen_vs;
		logic         sync_oe;
		logic [31:0]  rdata;
	} vidsmp_state_s;

endpackage : vidsmp_pkg

`default_nettype wire

// ---- vidsmp_regs.svh ----
`ifndef VIDSMP_REGS_SVH
`define VIDSMP_REGS_SVH

// ============================================================
// Register indexes on the plain register port
`define VIDSMP_ADDR_W           4
`define VIDSMP_REG_CTRL         4'h0
`define VIDSMP_REG_VWIN         4'h1
`define VIDSMP_REG_HWIN         4'h2
`define VIDSMP_REG_STATUS       4'h3
`define VIDSMP_REG_STILL        4'h4
`define VIDSMP_REG_GEN_TOT      4'h5
`define VIDSMP_REG_GEN_SYNC     4'h6

// ============================================================
// Control register fields
`define VIDSMP_CTRL_QUAL_SEL    0
`define VIDSMP_CTRL_FIELD_SRC   1
`define VIDSMP_CTRL_TOP_SEL     2
`define VIDSMP_CTRL_VEDGE       3
`define VIDSMP_CTRL_HEDGE       4
`define VIDSMP_CTRL_SYNC_INT    5
`define VIDSMP_CTRL_MODE_LSB    8
`define VIDSMP_CTRL_MODE_MSB    10
`define VIDSMP_CTRL_RESET       32'h0000_0005

// ============================================================
// Two-field registers: low field in [9:0], high field in [25:16]
`define VIDSMP_LO_LSB           0
`define VIDSMP_LO_MSB           9
`define VIDSMP_HI_LSB           16
`define VIDSMP_HI_MSB           25

// ============================================================
// Status register fields
`define VIDSMP_STAT_FIELD_TOP   0
`define VIDSMP_STAT_IN_WINDOW   1
`define VIDSMP_STAT_STILL_PEND  2
`define VIDSMP_STAT_STILL_AVAIL 3
`define VIDSMP_STAT_PIX_LSB     4
`define VIDSMP_STAT_PIX_MSB     13

// ============================================================
// Counter range and generator defaults
`define VIDSMP_CNT_MAX          10'h3ff
`define VIDSMP_HSYNC_WIDTH      10'h040
`define VIDSMP_LINE_TOT_RESET   10'h35a
`define VIDSMP_FRAME_TOT_RESET  10'h20d
`define VIDSMP_HS_START_RESET   10'h000
`define VIDSMP_VS_SIZE_RESET    10'h003

`endif

// ---- vidsmp_sampler_properties.sv ----
`default_nettype none

`include "vidsmp_regs.svh"

module vidsmp_sampler_checker
	import vidsmp_pkg::*;
(
	// Clock, reset and register port
	input wire logic                      i_clk,
	input wire logic                      i_reset,
	input wire logic [`VIDSMP_ADDR_W-1:0] i_addr,
	input wire logic                      i_rd,
	input wire logic [31:0]               o_rdata,
	// Video side
	input wire logic                      i_double_rate_pixel_clock,
	input wire logic                      o_hsync_oe,
	input wire logic                      o_vsync_oe,
	input wire vidsmp_pix_s               o_video_bus,
	input wire logic                      o_video_bus_oe,
	input wire vidsmp_pix_s               o_pixel,
	input wire logic                      o_pixel_valid
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	// ========================================================
	// Sampling path
	sequence s_rise_seen;
		$past(i_double_rate_pixel_clock, 3)
			&& !$past(i_double_rate_pixel_clock, 7);
	endsequence
	sequence s_quiet;
		!o_pixel_valid [*8];
	endsequence
	property p_valid_on_rise;
		o_pixel_valid |-> s_rise_seen;
	endproperty
	property p_valid_gap;
		o_pixel_valid |=> s_quiet;
	endproperty
	property p_ext_zero;
		o_pixel_valid |-> o_pixel.ext == 8'h00;
	endproperty
	property p_pixel_hold;
		$changed(o_pixel) |-> o_pixel_valid;
	endproperty
	property p_no_sample_still;
		o_video_bus_oe |-> !o_pixel_valid;
	endproperty
	a_valid_on_rise: assert property (p_valid_on_rise)
		else $error("pixel pulse without a pin clock rise");
	a_valid_gap: assert property (p_valid_gap)
		else $error("pixel pulses too close together");
	a_ext_zero: assert property (p_ext_zero)
		else $error("extended byte set on sampled pixel");
	a_pixel_hold: assert property (p_pixel_hold)
		else $error("pixel output moved without a capture");
	a_no_sample_still: assert property (p_no_sample_still)
		else $error("sampled pixel while driving the video bus");

	// ========================================================
	// Pin drive and register port
	property p_oe_pair;
		o_hsync_oe == o_vsync_oe;
	endproperty
	property p_still_syncs;
		o_video_bus_oe |-> o_hsync_oe;
	endproperty
	property p_bus_hold;
		$changed(o_video_bus) |-> o_video_bus_oe;
	endproperty
	property p_rd_zero;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	property p_unmapped;
		$past(i_rd) && ($past(i_addr) > `VIDSMP_REG_GEN_SYNC)
			|-> o_rdata == 32'h0;
	endproperty
	a_oe_pair: assert property (p_oe_pair)
		else $error("sync drive enables differ");
	a_still_syncs: assert property (p_still_syncs)
		else $error("video bus driven without syncs");
	a_bus_hold: assert property (p_bus_hold)
		else $error("video bus changed while released");
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data outside the answer cycle");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped index read nonzero");
endmodule : vidsmp_sampler_checker

bind vidsmp_video_input_sampler vidsmp_sampler_checker chk_inst (
	.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_double_rate_pixel_clock(i_double_rate_pixel_clock),
	.o_hsync_oe(o_hsync_oe), .o_vsync_oe(o_vsync_oe),
	.o_video_bus(o_video_bus), .o_video_bus_oe(o_video_bus_oe),
	.o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid)
);

`default_nettype wire

// ---- vidsmp_source_model.sv ----
`default_nettype none

// Video source: valid data on the qualified edge, junk on the other
module vidsmp_source_model (
	// Setup from the bench
	input  wire logic       i_qual_phase,
	input  wire logic       i_hpol,
	input  wire logic       i_vpol,
	// Pins toward the sampler
	output var  logic       o_pclk,
	output var  logic       o_qual,
	output var  logic [7:0] o_luma,
	output var  logic [7:0] o_chroma,
	output var  logic       o_hsync,
	output var  logic       o_vsync
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		o_pclk = 1'b1;
		o_qual = 1'b0;
		o_luma = 8'h00;
		o_chroma = 8'h00;
		o_hsync = 1'b0;
		o_vsync = 1'b0;
	end

	task automatic pix(input logic [7:0] x, input logic [7:0] ln,
		input logic hs, input logic vs);
		o_pclk = 1'b0;
		o_qual = ~i_qual_phase;
		o_luma = ~x;
		o_chroma = ~ln;
		o_hsync = hs ^ i_hpol;
		o_vsync = vs ^ i_vpol;
		#12 o_pclk = 1'b1;
		#12 o_pclk = 1'b0;
		o_qual = i_qual_phase;
		o_luma = x;
		o_chroma = ln;
		#12 o_pclk = 1'b1;
		#12;
	endtask : pix

	// Vsync line, then six lines of eight pixels; clock stops after
	task automatic run_frame;
		#1;
		for (int p = 0; p < 8; p++)
			pix(8'(p), 8'h00, 1'b0, (p >= 2) && (p < 6));
		for (int l = 1; l <= 6; l++)
			for (int p = 0; p < 8; p++)
				pix(8'(p), 8'(l), p == 0, 1'b0);
		o_luma = ~o_luma;
		o_chroma = ~o_chroma;
	endtask : run_frame
endmodule : vidsmp_source_model

`default_nettype wire

// ---- vidsmp_tb.sv ----
`default_nettype none

`include "vidsmp_regs.svh"

`define CHECK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end

module testbench
	import vidsmp_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic         qs;
		logic         hp;
		logic         vp;
		logic         fs;
		logic         ts;
		logic         fi;
		vidsmp_mode_e mode;
		logic [9:0]   fl;
		logic [9:0]   ll;
		logic [9:0]   fp;
		logic [9:0]   lp;
		logic [10:0]  n;
		logic         top;
	} vidsmp_row_s;

	localparam vidsmp_row_s ROWS [6] = '{
		'{1, 0, 0, 0, 1, 0, MODE_MOTION_COMP, 1, 6, 0, 7, 48, 0},
		'{0, 1, 0, 0, 1, 0, MODE_MOTION_DECOMP, 2, 3, 3, 5, 6, 1},
		'{1, 0, 1, 1, 1, 1, MODE_MPEG, 6, 6, 7, 7, 1, 1},
		'{0, 1, 1, 1, 0, 1, MODE_MOTION_COMP, 1, 1, 0, 0, 1, 0},
		'{1, 0, 0, 1, 0, 0, MODE_IDLE, 1, 6, 0, 7, 0, 1},
		'{1, 0, 0, 0, 0, 0, MODE_MPEG, 4, 3, 0, 7, 0, 1}
	};

	logic        i_clk, i_reset, i_wr, i_rd, qph, hpol, vpol, fi;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	logic        src_pclk, src_qual, src_hs, src_vs;
	logic [7:0]  src_luma, src_chroma;
	logic        o_hsync, o_hsync_oe, o_vsync, o_vsync_oe;
	logic        o_video_bus_oe, o_pixel_valid, o_field_top;
	vidsmp_pix_s o_video_bus, o_pixel;
	vidsmp_row_s r;
	logic [10:0] cnt, c0;
	int          num_errors, tests_run, cycles;
	wire logic   hs_pin;
	wire logic   vs_pin;
	wire logic [9:0] pix_x;
	wire logic [9:0] pix_y;

	assign hs_pin = o_hsync_oe ? o_hsync : src_hs;
	assign vs_pin = o_vsync_oe ? o_vsync : src_vs;
	assign pix_x = {2'h0, o_pixel.luma};
	assign pix_y = {2'h0, o_pixel.chroma};

	vidsmp_video_input_sampler vidsmp_video_input_sampler_inst (
		.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_double_rate_pixel_clock(src_pclk), .i_edge_qualifier(src_qual),
		.i_luma_bus(src_luma), .i_chroma_bus(src_chroma),
		.i_ext_bus(~src_luma), .i_field_indicator_in(fi),
		.i_hsync(hs_pin), .o_hsync(o_hsync), .o_hsync_oe(o_hsync_oe),
		.i_vsync(vs_pin), .o_vsync(o_vsync), .o_vsync_oe(o_vsync_oe),
		.o_video_bus(o_video_bus), .o_video_bus_oe(o_video_bus_oe),
		.o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid),
		.o_field_top(o_field_top)
	);

	vidsmp_source_model vidsmp_source_model_inst (
		.i_qual_phase(qph), .i_hpol(hpol), .i_vpol(vpol),
		.o_pclk(src_pclk), .o_qual(src_qual), .o_luma(src_luma),
		.o_chroma(src_chroma), .o_hsync(src_hs), .o_vsync(src_vs)
	);

	always #2 i_clk = ~i_clk;

	// ========================================================
	// Capture monitor and timeout
	always @(posedge i_clk) begin
		cycles++;
		if (o_pixel_valid === 1'b1) begin
			cnt = cnt + 11'h1;
			`CHECK(pix_x >= r.fp && pix_x <= r.lp, 1'b1)
			`CHECK(pix_y >= r.fl && pix_y <= r.ll, 1'b1)
		end
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask : reg_rd

	task automatic check_reset;
		i_reset <= 1'b1;
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		reg_rd(`VIDSMP_REG_CTRL, d);
		`CHECK(d, `VIDSMP_CTRL_RESET)
		`CHECK(o_hsync_oe, 1'b0)
		`CHECK(o_video_bus_oe, 1'b0)
		reg_rd(`VIDSMP_REG_VWIN, d);
		`CHECK(d, 32'h03ff_0000)
		reg_rd(4'hf, d);
		`CHECK(d, 32'h0000_0000)
		$display("test reset done");
	endtask : check_reset

	task automatic conclude;
		$display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	initial begin
		i_clk = 1'b0;
		i_reset = 1'b1;
		{i_wr, i_rd, i_addr, i_wdata} = '0;
		{qph, hpol, vpol, fi} = 4'h8;
		{cnt, num_errors, tests_run, cycles} = '0;
		r = ROWS[0];
		check_reset();
		foreach (ROWS[k]) begin
			@(posedge i_clk);
			r = ROWS[k];
			qph <= r.qs;
			hpol <= r.hp;
			vpol <= r.vp;
			fi <= r.fi;
			reg_wr(`VIDSMP_REG_VWIN, {6'h00, r.ll, 6'h00, r.fl});
			reg_wr(`VIDSMP_REG_HWIN, {6'h00, r.lp, 6'h00, r.fp});
			// Internal sync bit left clear: external syncs only
			reg_wr(`VIDSMP_REG_CTRL, {21'h0, r.mode, 3'h0, r.hp, r.vp,
				r.ts, r.fs, r.qs});
			cnt = 11'h0;
			vidsmp_source_model_inst.run_frame();
			repeat (8) @(posedge i_clk);
			`CHECK(cnt, r.n)
			`CHECK(o_field_top, r.top)
			$display("test row %0d done", k);
		end
		@(posedge i_clk);
		qph <= 1'b1;
		reg_wr(`VIDSMP_REG_GEN_TOT, 32'h0008_0008);
		reg_wr(`VIDSMP_REG_VWIN, 32'h03ff_0000);
		reg_wr(`VIDSMP_REG_HWIN, 32'h03ff_0000);
		reg_wr(`VIDSMP_REG_STILL, 32'h0012_3456);
		reg_wr(`VIDSMP_REG_CTRL, 32'h0000_0405);
		reg_rd(`VIDSMP_REG_STATUS, d);
		`CHECK(d[`VIDSMP_STAT_STILL_PEND], 1'b1)
		c0 = cnt;
		vidsmp_source_model_inst.run_frame();
		`CHECK(o_video_bus_oe, 1'b1)
		`CHECK(o_video_bus, 24'h123456)
		`CHECK(o_hsync_oe, 1'b1)
		`CHECK(o_hsync, 1'b1)
		`CHECK(cnt, c0)
		reg_rd(`VIDSMP_REG_STATUS, d);
		`CHECK(d[`VIDSMP_STAT_STILL_PEND], 1'b0)
		reg_wr(`VIDSMP_REG_CTRL, 32'h0000_0505);
		vidsmp_source_model_inst.run_frame();
		repeat (8) @(posedge i_clk);
		`CHECK(cnt, c0)
		reg_rd(`VIDSMP_REG_STILL, d);
		`CHECK(d, 32'h00f8_0607)
		reg_rd(`VIDSMP_REG_STATUS, d);
		`CHECK(d[`VIDSMP_STAT_STILL_AVAIL], 1'b0)
		reg_wr(`VIDSMP_REG_CTRL, 32'h0000_0225);
		repeat (2) @(posedge i_clk);
		#1;
		`CHECK(o_vsync_oe, 1'b1)
		`CHECK(o_video_bus_oe, 1'b0)
		$display("test still and internal sync done");
		check_reset();
		conclude();
	end
endmodule : testbench

`default_nettype wire

// ---- vidsmp_video_input_sampler.sv ----
// What this block does
// - Accepts a 4:2:2 bus: 8-bit luma and 8-bit multiplexed chroma.
// - Captures pixels and syncs on alternate rising doubled-clock edges only.
// - The edge qualifier level picks the valid edge of each pair.
// - Host sets which qualifier level marks a valid edge.
// - Select 1 samples where qualifier is high, 0 where it is low.
// - Capture advances on rising edges of the doubled pixel clock; the sync generator steps on falling edges.
// - A field identity signal is produced for downstream units.
// - With an external indicator, field identity comes from that pin.
// - A host bit sets which indicator level means the top field.
// - Without indicator, field is inferred from hsync level at vsync.
// - Top select 1 means high is top, 0 low is top; resets to 1.
// - Line and pixel counters reach 1023 each.
// - Pixels and lines outside the host window are discarded.
// - First line is first_line_count hsyncs after active vsync edge.
// - Last line is last_line_count hsyncs after active vsync edge.
// - First pixel is first_pixel_count clocks after active hsync edge.
// - Last pixel follows last_pixel_count; edge select 1 means falling.
// - Syncs come from the source or are generated and driven here.
// - Motion and MPEG modes route sampled video to the input path.
// - Motion decompression works with either sync source.
// - Still modes drive the syncs toward the codec; only still compression drives the 24-bit bus.
// - Still pixels move through a host register, not the sampler.
//
// The strobed register port and the placing of the registers were left to the implementer.
`default_nettype none

`include "vidsmp_regs.svh"

module vidsmp_video_input_sampler
	import vidsmp_pkg::*;
(
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_reset,
	// Register port
	input  wire logic [`VIDSMP_ADDR_W-1:0]  i_addr,
	input  wire logic [31:0]                i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output var  logic [31:0]                o_rdata,
	// Video pins
	input  wire logic                       i_double_rate_pixel_clock,
	input  wire logic                       i_edge_qualifier,
	input  wire logic [7:0]                 i_luma_bus,
	input  wire logic [7:0]                 i_chroma_bus,
	input  wire logic [7:0]                 i_ext_bus,
	input  wire logic                       i_field_indicator_in,
	// Two-way sync pins
	input  wire logic                       i_hsync,
	output var  logic                       o_hsync,
	output var  logic                       o_hsync_oe,
	input  wire logic                       i_vsync,
	output var  logic                       o_vsync,
	output var  logic                       o_vsync_oe,
	// Two-way 24-bit video bus, driven in still compression
	output var  vidsmp_pix_s                o_video_bus,
	output var  logic                       o_video_bus_oe,
	// Toward the input processing path
	output var  vidsmp_pix_s                o_pixel,
	output var  logic                       o_pixel_valid,
	output var  logic                       o_field_top
);

	// ========================================================
	// State
	vidsmp_state_s s;
	vidsmp_state_s next_s;

	vidsmp_pins_s pins_now;
	logic         pclk_stable;
	logic         rise;
	logic         fall;
	logic         qual_ok;
	logic         take;
	logic         gen_step;
	logic         hs_in;
	logic         vs_in;
	logic         hs_act;
	logic         vs_act;
	logic [9:0]   next_pix;
	logic [9:0]   next_line;
	logic         win;
	logic         motion_mode;
	logic         still_mode;
	logic         hs_level;
	logic         vs_level;

	assign pins_now.pclk     = i_double_rate_pixel_clock;
	assign pins_now.qual     = i_edge_qualifier;
	assign pins_now.hsync    = i_hsync;
	assign pins_now.vsync    = i_vsync;
	assign pins_now.field_in = i_field_indicator_in;
	assign pins_now.pix      = '{ext: i_ext_bus, chroma: i_chroma_bus,
		luma: i_luma_bus};

	// ========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.out_valid = 1'b0;
		hs_level = 1'b0;
		vs_level = 1'b0;

		// Three-stage synchroniser for every pin
		next_s.p1 = pins_now;
		next_s.p2 = s.p1;
		next_s.p3 = s.p2;

		// Doubled clock level only counts once stages two and three agree
		pclk_stable = (s.p2.pclk == s.p3.pclk);
		if (pclk_stable) begin
			next_s.pclk_lvl = s.p3.pclk;
		end
		rise = pclk_stable && s.p3.pclk && !s.pclk_lvl;
		fall = pclk_stable && !s.p3.pclk && s.pclk_lvl;
		qual_ok = (s.p3.qual == s.cfg.qual_sel);
		take = rise && qual_ok;
		gen_step = fall && qual_ok;

		motion_mode = (s.cfg.mode == MODE_MOTION_COMP) ||
			(s.cfg.mode == MODE_MOTION_DECOMP) ||
			(s.cfg.mode == MODE_MPEG);
		still_mode = (s.cfg.mode == MODE_STILL_COMP) ||
			(s.cfg.mode == MODE_STILL_DECOMP);

		// Sync source: own generator or the pins
		hs_in = s.sync_oe ? s.gen_hs : s.p3.hsync;
		vs_in = s.sync_oe ? s.gen_vs : s.p3.vsync;
		hs_act = s.cfg.hedge ? (s.hs_prev && !hs_in) :
			(!s.hs_prev && hs_in);
		vs_act = s.cfg.vedge ? (s.vs_prev && !vs_in) :
			(!s.vs_prev && vs_in);

		// Position counters, saturating at the top of their range
		next_pix = s.pix_cnt;
		next_line = s.line_cnt;
		if (hs_act) begin
			next_pix = 10'h000;
		end else if (s.pix_cnt != `VIDSMP_CNT_MAX) begin
			next_pix = s.pix_cnt + 10'h001;
		end
		if (vs_act) begin
			next_line = 10'h000;
		end else if (hs_act && (s.line_cnt != `VIDSMP_CNT_MAX)) begin
			next_line = s.line_cnt + 10'h001;
		end

		// Crop window on the counts reached at this edge
		win = (next_line >= s.cfg.first_line) &&
			(next_line <= s.cfg.last_line) &&
			(next_pix >= s.cfg.first_pix) &&
			(next_pix <= s.cfg.last_pix);

		if (take) begin
			next_s.hs_prev = hs_in;
			next_s.vs_prev = vs_in;
			next_s.pix_cnt = next_pix;
			next_s.line_cnt = next_line;
			next_s.in_win = win;

			// Field identity
			if (s.cfg.field_src) begin
				next_s.field_top = (s.p3.field_in == s.cfg.top_sel);
			end else if (vs_act) begin
				next_s.field_top = (hs_in == s.cfg.top_sel);
			end

			// Sampled pixels reach the input path only inside the window
			if (win && motion_mode) begin
				next_s.out_pix.luma = s.p3.pix.luma;
				next_s.out_pix.chroma = s.p3.pix.chroma;
				next_s.out_pix.ext = 8'h00;
				next_s.out_valid = 1'b1;
			end

			// Still decompression: codec pixel is caught for the host
			if (win && (s.cfg.mode == MODE_STILL_DECOMP)) begin
				next_s.still_in = s.p3.pix;
				next_s.still_avail = 1'b1;
			end

			// Still compression: host pixel is put on the bus
			if (win && (s.cfg.mode == MODE_STILL_COMP) && s.still_pend) begin
				next_s.bus_out = s.still_out;
				next_s.still_pend = 1'b0;
			end
		end

		// Sync generator steps on the qualified falling edges
		if (gen_step) begin
			if (s.gen_h >= s.cfg.line_tot - 10'h001) begin
				next_s.gen_h = 10'h000;
				if (s.gen_v >= s.cfg.frame_tot - 10'h001) begin
					next_s.gen_v = 10'h000;
				end else begin
					next_s.gen_v = s.gen_v + 10'h001;
				end
			end else begin
				next_s.gen_h = s.gen_h + 10'h001;
			end
			hs_level = (s.gen_h >= s.cfg.hs_start) &&
				(s.gen_h < s.cfg.hs_start + `VIDSMP_HSYNC_WIDTH);
			vs_level = (s.gen_v < s.cfg.vs_size);
			// Asserted level is low when the falling edge is the active one
			next_s.gen_hs = hs_level ^ s.cfg.hedge;
			next_s.gen_vs = vs_level ^ s.cfg.vedge;
		end

		next_s.sync_oe = s.cfg.sync_int || still_mode;
		next_s.bus_oe = (s.cfg.mode == MODE_STILL_COMP);

		// Register reads: data stand in the following cycle only
		next_s.rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				`VIDSMP_REG_CTRL: begin
					next_s.rdata[`VIDSMP_CTRL_QUAL_SEL] = s.cfg.qual_sel;
					next_s.rdata[`VIDSMP_CTRL_FIELD_SRC] = s.cfg.field_src;
					next_s.rdata[`VIDSMP_CTRL_TOP_SEL] = s.cfg.top_sel;
					next_s.rdata[`VIDSMP_CTRL_VEDGE] = s.cfg.vedge;
					next_s.rdata[`VIDSMP_CTRL_HEDGE] = s.cfg.hedge;
					next_s.rdata[`VIDSMP_CTRL_SYNC_INT] = s.cfg.sync_int;
					next_s.rdata[`VIDSMP_CTRL_MODE_MSB:`VIDSMP_CTRL_MODE_LSB] =
						s.cfg.mode;
				end
				`VIDSMP_REG_VWIN: begin
					next_s.rdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB] =
						s.cfg.first_line;
					next_s.rdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB] =
						s.cfg.last_line;
				end
				`VIDSMP_REG_HWIN: begin
					next_s.rdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB] =
						s.cfg.first_pix;
					next_s.rdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB] =
						s.cfg.last_pix;
				end
				`VIDSMP_REG_STATUS: begin
					next_s.rdata[`VIDSMP_STAT_FIELD_TOP] = s.field_top;
					next_s.rdata[`VIDSMP_STAT_IN_WINDOW] = s.in_win;
					next_s.rdata[`VIDSMP_STAT_STILL_PEND] = s.still_pend;
					next_s.rdata[`VIDSMP_STAT_STILL_AVAIL] = s.still_avail;
					next_s.rdata[`VIDSMP_STAT_PIX_MSB:`VIDSMP_STAT_PIX_LSB] =
						s.pix_cnt;
					next_s.rdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB] = s.line_cnt;
				end
				`VIDSMP_REG_STILL: begin
					next_s.rdata[23:0] = s.still_in;
					// Capture in this same cycle keeps the flag set
					if (!(take && win &&
						(s.cfg.mode == MODE_STILL_DECOMP))) begin
						next_s.still_avail = 1'b0;
					end
				end
				`VIDSMP_REG_GEN_TOT: begin
					next_s.rdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB] = s.cfg.line_tot;
					next_s.rdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB] =
						s.cfg.frame_tot;
				end
				`VIDSMP_REG_GEN_SYNC: begin
					next_s.rdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB] = s.cfg.hs_start;
					next_s.rdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB] = s.cfg.vs_size;
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Register writes
		if (i_wr) begin
			case (i_addr)
				`VIDSMP_REG_CTRL: begin
					next_s.cfg.qual_sel = i_wdata[`VIDSMP_CTRL_QUAL_SEL];
					next_s.cfg.field_src = i_wdata[`VIDSMP_CTRL_FIELD_SRC];
					next_s.cfg.top_sel = i_wdata[`VIDSMP_CTRL_TOP_SEL];
					next_s.cfg.vedge = i_wdata[`VIDSMP_CTRL_VEDGE];
					next_s.cfg.hedge = i_wdata[`VIDSMP_CTRL_HEDGE];
					next_s.cfg.sync_int = i_wdata[`VIDSMP_CTRL_SYNC_INT];
					next_s.cfg.mode = vidsmp_mode_e'(
						i_wdata[`VIDSMP_CTRL_MODE_MSB:`VIDSMP_CTRL_MODE_LSB]);
				end
				`VIDSMP_REG_VWIN: begin
					next_s.cfg.first_line =
						i_wdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB];
					next_s.cfg.last_line =
						i_wdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB];
				end
				`VIDSMP_REG_HWIN: begin
					next_s.cfg.first_pix =
						i_wdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB];
					next_s.cfg.last_pix =
						i_wdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB];
				end
				`VIDSMP_REG_STILL: begin
					next_s.still_out = i_wdata[23:0];
					next_s.still_pend = 1'b1;
				end
				`VIDSMP_REG_GEN_TOT: begin
					next_s.cfg.line_tot = i_wdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB];
					next_s.cfg.frame_tot =
						i_wdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB];
				end
				`VIDSMP_REG_GEN_SYNC: begin
					next_s.cfg.hs_start = i_wdata[`VIDSMP_LO_MSB:`VIDSMP_LO_LSB];
					next_s.cfg.vs_size = i_wdata[`VIDSMP_HI_MSB:`VIDSMP_HI_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	// ========================================================
	// Registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s <= '0;
			s.cfg.qual_sel <= 1'(`VIDSMP_CTRL_RESET >> `VIDSMP_CTRL_QUAL_SEL);
			// Pin clock idles high: start level matches so no false edge
			s.pclk_lvl <= 1'b1;
			s.p1.pclk <= 1'b1;
			s.p2.pclk <= 1'b1;
			s.p3.pclk <= 1'b1;
			s.cfg.top_sel <= 1'b1;
			s.cfg.mode <= MODE_IDLE;
			s.cfg.last_line <= `VIDSMP_CNT_MAX;
			s.cfg.last_pix <= `VIDSMP_CNT_MAX;
			s.cfg.line_tot <= `VIDSMP_LINE_TOT_RESET;
			s.cfg.frame_tot <= `VIDSMP_FRAME_TOT_RESET;
			s.cfg.hs_start <= `VIDSMP_HS_START_RESET;
			s.cfg.vs_size <= `VIDSMP_VS_SIZE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ========================================================
	// Outputs
	assign o_rdata        = s.rdata;
	assign o_hsync        = s.gen_hs;
	assign o_hsync_oe     = s.sync_oe;
	assign o_vsync        = s.gen_vs;
	assign o_vsync_oe     = s.sync_oe;
	assign o_video_bus    = s.bus_out;
	assign o_video_bus_oe = s.bus_oe;
	assign o_pixel        = s.out_pix;
	assign o_pixel_valid  = s.out_valid;
	assign o_field_top    = s.field_top;

endmodule : vidsmp_video_input_sampler

`default_nettype wire
